// >>> srr_pkg.sv
// package: constants and types for the serial receive recovery block
package srr_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_DIVISOR = 5'h00;
  localparam logic [4:0] OFS_CONTROL_ONE = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0C;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h10;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h14;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CTL_NINE_BIT = 0;
  localparam int CTL_FULL_IRQ = 1;
  localparam int CTL_RX_ENABLE = 2;
  localparam int DIV_WIDTH = 13;
  localparam logic [12:0] DIVISOR_RESET = 13'h0001;
  localparam logic [2:0] CONTROL_RESET = 3'h0;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // ------------------------------------------------------------
  // oversampling tick positions within one bit
  // ------------------------------------------------------------
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_VERIFY_A = 5'h03;
  localparam logic [4:0] RT_VERIFY_B = 5'h05;
  localparam logic [4:0] RT_VERIFY_C = 5'h07;
  localparam logic [4:0] RT_MID_A = 5'h08;
  localparam logic [4:0] RT_MID_B = 5'h09;
  localparam logic [4:0] RT_MID_C = 5'h0A;
  localparam logic [4:0] RT_LAST = 5'h10;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRR_HUNT,
    SRR_START,
    SRR_DATA,
    SRR_STOP
  } srr_state_t;

  // status layout, shared by status, clear and enable registers
  typedef struct packed {
    logic framingErrorFlag;
    logic noiseFlag;
    logic rxFullFlag;
  } srr_flags_t;

endpackage

// >>> srr_receiver.sv
// module: oversampled asynchronous serial receiver with Avalon-MM slave
// Summary of operation
// - accept eight or nine data bits
// - shift frame in, move data to buffer
// - buffer load sets full flag, may interrupt
// - sample pin on sixteen-times oversampling tick
// - resync after start and one-to-zero change
// - start search: zero after three ones
// - verify start at ticks three, five, seven
// - failed verify restarts search, no noise
// - data bit by majority of ticks 8-10
// - start mid samples only raise noise
// - stop majority zero gives framing error
// - break character also gives framing error
// - framing error with full flag, blocks reception
// - frame is start, data, stop bits
// - length bit set selects nine bits
// - thirteen-bit divisor counter makes tick
`timescale 1ns/1ps
module srr_receiver #(
  parameter int ADDR_W = 5,
  parameter int DIV_W = srr_pkg::DIV_WIDTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxPin,
  output logic irq
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (DIV_W != srr_pkg::DIV_WIDTH) begin : g_bad_div
    $error("divisor width must be thirteen");
  end
  if (ADDR_W < 5) begin : g_bad_addr
    $error("address must be at least five bits");
  end

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // samples not all equal
  function automatic logic split3(input logic [2:0] s);
    split3 = (s != 3'b000) && (s != 3'b111);
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [1:0] pinSync;
  logic rxIn;
  logic [DIV_W-1:0] divisor;
  logic [DIV_W-1:0] divCount;
  logic tick;
  logic [2:0] control;
  srr_pkg::srr_flags_t flags;
  srr_pkg::srr_flags_t irqEnable;
  srr_pkg::srr_flags_t events;
  srr_pkg::srr_flags_t clearMask;
  srr_pkg::srr_state_t state;
  logic [4:0] rtCount;
  logic [2:0] hist;
  logic [2:0] samples;
  logic [3:0] bitIndex;
  logic [8:0] shifter;
  logic [8:0] dataBuf;
  logic lastBit;
  logic ack;
  logic accept;
  logic [4:0] regAddr;
  logic nineBit;
  logic rxEnable;
  logic [3:0] frameBits;
  logic [2:0] midSet;
  logic bitValue;
  logic earlyEdge;
  logic lateEdge;
  logic [2:0] startSet;

  assign regAddr = avs_address[4:0];
  assign nineBit = control[srr_pkg::CTL_NINE_BIT];
  assign rxEnable = control[srr_pkg::CTL_RX_ENABLE];

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  // pin is asynchronous; only the second stage is read below
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinSync <= 2'b11;
    end else begin
      pinSync <= {pinSync[0], rxPin};
    end
  end
  assign rxIn = pinSync[1];

  // ------------------------------------------------------------
  // oversampling tick
  // ------------------------------------------------------------
  // modulus counter reloads from divisor; a zero divisor stops it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divCount <= srr_pkg::DIVISOR_RESET;
    end else if (divisor == '0) begin
      divCount <= '0;
    end else if (divCount <= DIV_W'(1)) begin
      divCount <= divisor;
    end else begin
      divCount <= divCount - DIV_W'(1);
    end
  end
  assign tick = (divisor != '0) && (divCount <= DIV_W'(1));

  // ------------------------------------------------------------
  // bit decode terms
  // ------------------------------------------------------------
  // mid samples with the live sample standing in for tick ten
  assign midSet = {rxIn, samples[1:0]};
  assign bitValue = maj3(midSet);
  assign startSet = {rxIn, samples[1:0]};
  assign frameBits = nineBit ? srr_pkg::BITS_NINE
                             : srr_pkg::BITS_EIGHT;
  // falling edge after a one bit: before mid samples or after them
  assign earlyEdge = lastBit && hist[0] && !rxIn &&
                     (rtCount < srr_pkg::RT_VERIFY_C) &&
                     (rtCount != '0);
  assign lateEdge = lastBit && hist[0] && !rxIn &&
                    (rtCount > srr_pkg::RT_MID_C);

  // ------------------------------------------------------------
  // receive state machine
  // ------------------------------------------------------------
  // one process owns the frame sequence and its sample store
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= srr_pkg::SRR_HUNT;
      rtCount <= '0;
      hist <= 3'b000;
      samples <= 3'b000;
      bitIndex <= '0;
      shifter <= '0;
      lastBit <= 1'b0;
    end else if (!rxEnable) begin
      state <= srr_pkg::SRR_HUNT;
      rtCount <= '0;
      hist <= 3'b000;
    end else if (tick) begin
      hist <= {hist[1:0], rxIn};
      case (state)
        srr_pkg::SRR_HUNT: begin
          rtCount <= '0;
          // no new frame while a framing error is pending
          if (hist == 3'b111 && !rxIn &&
              !flags.framingErrorFlag) begin
            state <= srr_pkg::SRR_START;
            rtCount <= srr_pkg::RT_FIRST;
          end
        end
        srr_pkg::SRR_START: begin
          rtCount <= rtCount + 5'h01;
          if (rtCount + 5'h01 == srr_pkg::RT_VERIFY_A) begin
            samples[0] <= rxIn;
          end
          if (rtCount + 5'h01 == srr_pkg::RT_VERIFY_B) begin
            samples[1] <= rxIn;
          end
          if (rtCount + 5'h01 == srr_pkg::RT_VERIFY_C &&
              maj3(startSet)) begin
            // two or more ones: false start, no noise flag, search again
            state <= srr_pkg::SRR_HUNT;
            rtCount <= '0;
            hist <= 3'b000;
          end
          if (rtCount == srr_pkg::RT_LAST) begin
            state <= srr_pkg::SRR_DATA;
            rtCount <= srr_pkg::RT_FIRST;
            bitIndex <= '0;
            lastBit <= 1'b0; // start bit always counts as zero
          end
        end
        srr_pkg::SRR_DATA, srr_pkg::SRR_STOP: begin
          rtCount <= rtCount + 5'h01;
          if (rtCount + 5'h01 == srr_pkg::RT_MID_A) begin
            samples[0] <= rxIn;
          end
          if (rtCount + 5'h01 == srr_pkg::RT_MID_B) begin
            samples[1] <= rxIn;
          end
          if (rtCount + 5'h01 == srr_pkg::RT_MID_C) begin
            if (state == srr_pkg::SRR_STOP) begin
              // stop decided: hunt at once for the next start
              state <= srr_pkg::SRR_HUNT;
              rtCount <= '0;
              hist <= bitValue ? 3'b111 : 3'b000;
            end else begin
              shifter <= {bitValue, shifter[8:1]};
              lastBit <= bitValue;
            end
          end
          if (state == srr_pkg::SRR_DATA && earlyEdge) begin
            rtCount <= srr_pkg::RT_FIRST;
          end
          if (state == srr_pkg::SRR_DATA &&
              (rtCount == srr_pkg::RT_LAST || lateEdge)) begin
            rtCount <= srr_pkg::RT_FIRST;
            bitIndex <= bitIndex + 4'h1;
            if (bitIndex + 4'h1 == frameBits) begin
              state <= srr_pkg::SRR_STOP;
            end
          end
        end
        default: begin
          state <= srr_pkg::SRR_HUNT;
          rtCount <= '0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // frame events
  // ------------------------------------------------------------
  // all events are single-cycle, qualified by the tick
  always_comb begin
    events = '0;
    if (tick && rxEnable) begin
      if (state == srr_pkg::SRR_START) begin
        if (rtCount + 5'h01 == srr_pkg::RT_VERIFY_C) begin
          // exactly one high verify sample is noise
          events.noiseFlag = split3(startSet) &&
                             !maj3(startSet);
        end
        if (rtCount + 5'h01 >= srr_pkg::RT_MID_A &&
            rtCount + 5'h01 <= srr_pkg::RT_MID_C && rxIn) begin
          events.noiseFlag = 1'b1;
        end
      end
      if ((state == srr_pkg::SRR_DATA ||
           state == srr_pkg::SRR_STOP) &&
          rtCount + 5'h01 == srr_pkg::RT_MID_C) begin
        events.noiseFlag = split3(midSet);
      end
      if (state == srr_pkg::SRR_STOP &&
          rtCount + 5'h01 == srr_pkg::RT_MID_C) begin
        events.rxFullFlag = 1'b1;
        events.framingErrorFlag = !bitValue;
      end
    end
  end

  // ------------------------------------------------------------
  // receive data buffer
  // ------------------------------------------------------------
  // eight-bit frames sit one place high in the shifter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataBuf <= '0;
    end else if (events.rxFullFlag) begin
      dataBuf <= nineBit ? shifter
                         : {1'b0, shifter[8:1]};
    end
  end

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // one wait cycle per access; the second cycle completes it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign accept = ack && (avs_read || avs_write);

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divisor <= srr_pkg::DIVISOR_RESET;
      control <= srr_pkg::CONTROL_RESET;
      irqEnable <= srr_pkg::FLAGS_RESET;
    end else if (accept && avs_write) begin
      case (regAddr)
        srr_pkg::OFS_DIVISOR: begin
          divisor <= avs_writedata[DIV_W-1:0];
        end
        srr_pkg::OFS_CONTROL_ONE: begin
          control <= avs_writedata[2:0];
          irqEnable.rxFullFlag <=
            avs_writedata[srr_pkg::CTL_FULL_IRQ];
        end
        srr_pkg::OFS_IRQ_ENABLE: begin
          irqEnable <= avs_writedata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // sticky status flags
  // ------------------------------------------------------------
  // clear by write of ones, full also by reading data; set wins
  always_comb begin
    clearMask = '0;
    if (accept && avs_write && regAddr == srr_pkg::OFS_IRQ_CLEAR) begin
      clearMask = avs_writedata[2:0];
    end
    if (accept && avs_read && regAddr == srr_pkg::OFS_DATA) begin
      clearMask.rxFullFlag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= srr_pkg::FLAGS_RESET;
    end else begin
      flags <= (flags & ~clearMask) | events;
    end
  end

  assign irq = |(flags & irqEnable);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // captured in the wait cycle, valid when waitrequest drops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      case (regAddr)
        srr_pkg::OFS_DIVISOR: begin
          avs_readdata <= {19'h0, divisor};
        end
        srr_pkg::OFS_CONTROL_ONE: begin
          avs_readdata <= {29'h0, control[2],
                           irqEnable.rxFullFlag, control[0]};
        end
        srr_pkg::OFS_STATUS: begin
          avs_readdata <= {28'h0, state != srr_pkg::SRR_HUNT,
                           flags};
        end
        srr_pkg::OFS_DATA: begin
          avs_readdata <= {23'h0, dataBuf};
        end
        srr_pkg::OFS_IRQ_ENABLE: begin
          avs_readdata <= {29'h0, irqEnable};
        end
        default: begin
          avs_readdata <= '0;
        end
      endcase
    end
  end

endmodule

// >>> srr_receiver_assertions.sv
// checker: port-level assertions for the serial receive recovery block
`timescale 1ns/1ps
module srr_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rxPin,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // bus handshake steps
  // ------------------------------------------------------------
  sequence s_new;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence s_rdack;
    avs_read && !avs_waitrequest;
  endsequence

  AST_WAIT_FIRST: assert property (s_new |-> avs_waitrequest)
    else $error("no wait cycle on a new request");
  AST_ONE_WAIT: assert property (s_new |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  AST_IDLE_FREE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait asserted with no request");
  AST_READ_HOLD: assert property (!$past(avs_read) && !$past(sys_rst)
    |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (s_rdack ##0 avs_address >= 5'h18
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_DATA_WIDTH: assert property (s_rdack ##0
    avs_address == srr_pkg::OFS_DATA |-> avs_readdata[31:9] == 23'h0)
    else $error("data read has upper bits set");
  AST_RST_IRQ: assert property ($past(sys_rst) |-> !irq)
    else $error("interrupt high after reset");
  // irq may only drop because software wrote or read something
  AST_IRQ_FALL: assert property ($fell(irq) && !$past(sys_rst)
    |-> $past((avs_read || avs_write) && !avs_waitrequest))
    else $error("interrupt fell with no access");
  AST_MASK: assert property (avs_write && !avs_waitrequest
    && avs_address == srr_pkg::OFS_IRQ_ENABLE && avs_writedata[2:0] == 3'h0
    |=> !irq [*2])
    else $error("interrupt high while masked");
endmodule

bind srr_receiver srr_chk chk_u (.clk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rxPin, .irq);

// >>> srr_tx_model.sv
// partner: remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module srr_tx_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic nine,
  input wire logic glitch,
  input wire logic [8:0] data,
  input wire logic stopVal,
  input wire logic [3:0] noiseBit,
  input wire logic [4:0] noiseOff,
  input wire logic [5:0] bitLen,
  output logic busy,
  output logic rxPin
);
  int cyc;
  logic [10:0] frame;

  // ------------------------------------------------------------
  // frame timing
  // ------------------------------------------------------------
  // bit length is free so the bench can run the line slow
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      cyc <= 0;
    end else if (busy) begin
      if (cyc == (glitch ? 1 : (nine ? 11 : 10) * bitLen - 1))
        busy <= 1'b0;
      cyc <= cyc + 1;
    end
  end

  // start low, data lsb first, stop; a glitch is a lone short low
  always_comb begin
    frame = nine ? {stopVal, data, 1'b0}
                 : {1'b1, stopVal, data[7:0], 1'b0};
    rxPin = 1'b1;
    if (busy) begin
      rxPin = frame[cyc / bitLen] ^ (cyc / bitLen == noiseBit
              && cyc % bitLen == noiseOff);
    end
  end
endmodule

// >>> async_serial_receiver_recovery_tb.sv
// testbench: table-driven checks of the serial receive recovery block
`timescale 1ns/1ps
module async_serial_receiver_recovery_tb;
  typedef struct packed {
    logic clr; logic nine; logic gl; logic [8:0] d; logic sb;
    logic [3:0] nb; logic [4:0] no; logic [5:0] len;
    logic [8:0] ed; logic [2:0] ef;
  } srr_row_t;
  logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [4:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic avs_waitrequest, rxPin, irq, busy;
  logic go = 0, nine = 0, gl = 0, sb = 1;
  logic [8:0] d = 0;
  logic [3:0] nb = 4'hF;
  logic [4:0] no = 0;
  logic [5:0] len = 6'h10;
  int n_errors = 0, checks = 0, cycles = 0;
  srr_row_t rows [11];

  always #5 clk = ~clk;

  srr_receiver dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rxPin, .irq);
  srr_tx_model far_u (.clk, .sys_rst, .go, .nine, .glitch(gl), .data(d),
    .stopVal(sb), .noiseBit(nb), .noiseOff(no), .bitLen(len), .busy, .rxPin);

  task give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hung handshake must still reach the report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end

  task chk(input string nm, input logic [8:0] e, input logic [8:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  // one access; waitrequest and read data are taken at the rising edge,
  // and only the bench timeout ends a wait that never answers
  task bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task send(input srr_row_t r);
    int n;
    n = 0;
    @(posedge clk);
    {nine, gl, d, sb, nb, no, len} <= {r.nine, r.gl, r.d, r.sb, r.nb, r.no, r.len};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 800) begin
      n++;
      @(negedge clk);
    end
    if (n == 800) chk("frame", 9'h000, 9'h001);
    repeat (20) @(posedge clk);
  endtask

  task irqis(input logic e);
    @(negedge clk);
    chk("irq", 9'(e), 9'(irq));
  endtask

  initial begin
    // clr nine gl data stop noisebit noiseoff len expdata expflags
    rows = '{'{1, 0, 0, 9'h0A5, 1, 15, 0, 16, 9'h0A5, 3'h1},
             '{1, 0, 1, 9'h000, 1, 15, 0, 16, 9'h000, 3'h0},
             '{1, 1, 0, 9'h15A, 1, 15, 0, 16, 9'h15A, 3'h1},
             '{1, 0, 0, 9'h03C, 1, 3, 8, 16, 9'h03C, 3'h3},
             '{1, 0, 0, 9'h0C3, 1, 0, 4, 16, 9'h0C3, 3'h3},
             '{1, 0, 0, 9'h099, 1, 0, 8, 16, 9'h099, 3'h3},
             '{1, 0, 0, 9'h0E7, 1, 9, 8, 16, 9'h0E7, 3'h3},
             '{1, 0, 0, 9'h055, 1, 15, 0, 18, 9'h055, 3'h1},
             '{1, 0, 0, 9'h000, 0, 15, 0, 16, 9'h000, 3'h5},
             '{0, 0, 0, 9'h081, 1, 15, 0, 16, 9'h000, 3'h4},
             '{1, 1, 0, 9'h1FF, 0, 15, 0, 16, 9'h1FF, 3'h5}};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, srr_pkg::OFS_DIVISOR, 0);
    chk("divisor", 9'h001, q[8:0]);
    bus(0, srr_pkg::OFS_CONTROL_ONE, 0);
    chk("control", 9'h000, q[8:0]);
    bus(0, srr_pkg::OFS_STATUS, 0);
    chk("status", 9'h000, q[8:0]);
    bus(1, 5'h18, 32'hFFFF_FFFF);
    bus(0, 5'h18, 0);
    chk("unmapped", 9'h000, q[8:0]);
    // table: clean, glitch, nine-bit, noise, slow line, break, blocked
    foreach (rows[i]) begin
      if (rows[i].clr) bus(1, srr_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
      bus(1, srr_pkg::OFS_CONTROL_ONE, {29'h0, 2'h2, rows[i].nine});
      send(rows[i]);
      bus(0, srr_pkg::OFS_STATUS, 0);
      chk("flags", 9'(rows[i].ef), q[8:0]);
      if (rows[i].ef[0]) begin
        bus(0, srr_pkg::OFS_DATA, 0);
        chk("data", rows[i].ed, q[8:0]);
        bus(0, srr_pkg::OFS_STATUS, 0);
        chk("full", 9'h000, 9'(q[0]));
      end
    end
    // slower tick, then interrupt raised, masked, re-enabled, cleared
    bus(1, srr_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
    bus(1, srr_pkg::OFS_DIVISOR, 32'h0000_0002);
    bus(1, srr_pkg::OFS_CONTROL_ONE, 32'h0000_0004);
    bus(1, srr_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    send('{0, 0, 0, 9'h05A, 1, 15, 0, 32, 9'h000, 3'h0});
    irqis(1'b1);
    bus(1, srr_pkg::OFS_IRQ_ENABLE, 0);
    irqis(1'b0);
    bus(1, srr_pkg::OFS_CONTROL_ONE, 32'h0000_0006);
    irqis(1'b1);
    bus(0, srr_pkg::OFS_DATA, 0);
    chk("data", 9'h05A, q[8:0]);
    irqis(1'b0);
    give_verdict;
  end
endmodule
